// *** logic/srbc_regs.svh ***
// Purpose : register map, field layout and reset values of the read burst
//           control block
// Assumes : included by bare name wherever a value is needed
// Notes   : offsets are byte addresses on the AXI4-Lite register bus
`ifndef SRBC_REGS_SVH
`define SRBC_REGS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define SRBC_CFG_OFS      4'h0
`define SRBC_STAT_OFS     4'h4

// ----------------------------------------------------------------------
// configuration fields
// ----------------------------------------------------------------------
`define SRBC_CFG_LAT_LSB  0
`define SRBC_CFG_LAT_MSB  1
`define SRBC_CFG_BL_LSB   4
`define SRBC_CFG_BL_MSB   6
`define SRBC_LAT_RST      2'h2
`define SRBC_BL_RST       3'h2
`define SRBC_LAT_MIN      2'h1

// ----------------------------------------------------------------------
// burst length codes
// ----------------------------------------------------------------------
`define SRBC_BL_1         3'h0
`define SRBC_BL_2         3'h1
`define SRBC_BL_4         3'h2
`define SRBC_BL_8         3'h3

// ----------------------------------------------------------------------
// status fields and pin layout
// ----------------------------------------------------------------------
`define SRBC_STAT_BUSY    4
`define SRBC_STAT_DRIVE   5
`define SRBC_AP_BIT       10
`define SRBC_PAGE_LAST    4'hF

// ----------------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------------
`define SRBC_RESP_OKAY    2'h0
`define SRBC_RESP_SLVERR  2'h2

`endif

// *** logic/srbc_pkg.sv ***
// Purpose : types shared by the read burst control block
// Assumes : constants live in srbc_regs.svh
// Notes   : one packed struct carries all state of the top module
package srbc_pkg;

  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_ACT,
    CMD_RD,
    CMD_WR,
    CMD_PRE,
    CMD_BST,
    CMD_OTHER
  } srbc_cmd_t;

  typedef struct packed {
    logic [1:0]        lat;     // read latency setting
    logic [2:0]        bl;      // burst length code
    logic [3:0]        open;    // row open per bank
    logic [3:0][11:0]  row;     // open row per bank
    logic              burst;   // more beats to read
    logic              ap;      // auto precharge of running burst
    logic [1:0]        bank;
    logic [3:0]        start;
    logic [3:0]        cnt;
    logic [2:0]        pv;      // valid of pipeline stages
    logic [31:0]       d2;
    logic [31:0]       d3;
    logic              dqm1;
    logic              dqm2;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
  } srbc_state_t;

endpackage

// *** logic/srbc_mem.sv ***
// Purpose : small data array of the four banks
// Assumes : one write and one read port on aclk
// Notes   : read data comes out of a register, one cycle after address
`timescale 1ns/1ps

module srbc_mem (
  input  wire logic        aclk,   // system clock
  input  wire logic        we,     // write strobe
  input  wire logic [7:0]  waddr,  // write word address
  input  wire logic [31:0] wdata,  // write word
  input  wire logic [7:0]  raddr,  // read word address
  output logic      [31:0] rdata   // registered read word
);

  logic [31:0] mem [0:255];

  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

// *** logic/srbc_top.sv ***
// Purpose : read side command and data sequencing of a four bank DRAM
// Assumes : command pins come from logic on aclk; registers on AXI4-Lite
// Notes   : array holds 4 rows x 16 columns per bank; page is 16 words
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "srbc_regs.svh"

module srbc_top (
  input  wire logic        aclk,     // system clock, 250 MHz
  input  wire logic        aresetn,  // synchronous reset, active low
  input  wire logic [3:0]  awaddr,   // write address
  input  wire logic        awvalid,  // write address valid
  output logic             awready,  // write address ready
  input  wire logic [31:0] wdata,    // write data
  input  wire logic [3:0]  wstrb,    // write byte enables
  input  wire logic        wvalid,   // write data valid
  output logic             wready,   // write data ready
  output logic      [1:0]  bresp,    // write response
  output logic             bvalid,   // write response valid
  input  wire logic        bready,   // write response ready
  input  wire logic [3:0]  araddr,   // read address
  input  wire logic        arvalid,  // read address valid
  output logic             arready,  // read address ready
  output logic      [31:0] rdata,    // read data
  output logic      [1:0]  rresp,    // read response
  output logic             rvalid,   // read data valid
  input  wire logic        rready,   // read data ready
  input  wire logic        cs_n,     // chip select, active low
  input  wire logic        ras_n,    // row strobe, active low
  input  wire logic        cas_n,    // column strobe, active low
  input  wire logic        we_n,     // write enable, active low
  input  wire logic [1:0]  ba,       // bank address
  input  wire logic [11:0] addr,     // row or column address
  input  wire logic        dqm,      // data mask, active high
  input  wire logic [31:0] dq_in,    // data lines, input side
  output logic      [31:0] dq_out,   // data lines, output side
  output logic             dq_oe     // data lines driven
);

  // --------------------------------------------------------------------
  // functions
  // --------------------------------------------------------------------
  function automatic srbc_pkg::srbc_cmd_t decode(
    input logic c, input logic r, input logic k, input logic w);
    if (c) begin
      decode = srbc_pkg::CMD_NOP;
    end else begin
      unique case ({r, k, w})
        3'h7:    decode = srbc_pkg::CMD_NOP;
        3'h3:    decode = srbc_pkg::CMD_ACT;
        3'h5:    decode = srbc_pkg::CMD_RD;
        3'h4:    decode = srbc_pkg::CMD_WR;
        3'h2:    decode = srbc_pkg::CMD_PRE;
        3'h6:    decode = srbc_pkg::CMD_BST;
        default: decode = srbc_pkg::CMD_OTHER;
      endcase
    end
  endfunction

  // column offset mask of a burst; unknown codes run as full page
  function automatic logic [3:0] bl_mask(input logic [2:0] code);
    unique case (code)
      `SRBC_BL_1: bl_mask = 4'h0;
      `SRBC_BL_2: bl_mask = 4'h1;
      `SRBC_BL_4: bl_mask = 4'h3;
      `SRBC_BL_8: bl_mask = 4'h7;
      default:    bl_mask = `SRBC_PAGE_LAST;
    endcase
  endfunction

  // sequential column inside the burst block, wrapping within the block
  function automatic logic [3:0] col_at(
    input logic [3:0] start, input logic [3:0] cnt, input logic [3:0] m);
    logic [3:0] sum;
    sum    = start + cnt;
    col_at = (start & ~m) | (sum & m);
  endfunction

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  localparam srbc_pkg::srbc_state_t RST = '{
    lat: `SRBC_LAT_RST, bl: `SRBC_BL_RST, default: '0};

  srbc_pkg::srbc_state_t s_r, s_nxt;
  srbc_pkg::srbc_cmd_t   cmd;
  logic                  stop;
  logic                  full;
  logic                  rd_issue;
  logic [7:0]            rd_addr;
  logic                  mem_we;
  logic [7:0]            wr_addr;
  logic [31:0]           mem_rdata;
  logic                  out_v;
  logic                  rd_busy;
  logic                  aw_go;
  logic [3:0]            m;

  srbc_mem u_mem (
    .aclk  (aclk),
    .we    (mem_we),
    .waddr (wr_addr),
    .wdata (dq_in),
    .raddr (rd_addr),
    .rdata (mem_rdata)
  );

  // --------------------------------------------------------------------
  // command sequencing and register bus
  // --------------------------------------------------------------------
  always_comb begin
    s_nxt    = s_r;
    cmd      = decode(cs_n, ras_n, cas_n, we_n);
    m        = bl_mask(s_r.bl);
    full     = (m == `SRBC_PAGE_LAST);
    rd_busy  = s_r.burst | (|s_r.pv);
    rd_issue = 1'b0;
    rd_addr  = {s_r.bank, s_r.row[s_r.bank][1:0], col_at(s_r.start,
                s_r.cnt, m)};
    wr_addr  = {ba, s_r.row[ba][1:0], addr[3:0]};
    mem_we   = 1'b0;
    stop     = (cmd == srbc_pkg::CMD_RD) || (cmd == srbc_pkg::CMD_WR) ||
               (cmd == srbc_pkg::CMD_BST) ||
               (cmd == srbc_pkg::CMD_PRE &&
                (addr[`SRBC_AP_BIT] || ba == s_r.bank));
    // running burst: one column per clock
    if (s_r.burst && !stop) begin
      rd_issue  = 1'b1;
      s_nxt.cnt = s_r.cnt + 4'h1;
      if (!full && s_r.cnt == m) begin
        s_nxt.burst = 1'b0;
        if (s_r.ap) begin
          s_nxt.open[s_r.bank] = 1'b0;
        end
      end
    end
    unique case (cmd)
      srbc_pkg::CMD_RD: begin
        // any cycle, any bank, cuts the running burst
        rd_issue    = 1'b1;
        rd_addr     = {ba, s_r.row[ba][1:0], addr[3:0]};
        s_nxt.bank  = ba;
        s_nxt.start = addr[3:0];
        s_nxt.ap    = addr[`SRBC_AP_BIT];
        s_nxt.cnt   = 4'h1;
        s_nxt.burst = (m != 4'h0);
        if (m == 4'h0 && addr[`SRBC_AP_BIT]) begin
          s_nxt.open[ba] = 1'b0;
        end
      end
      srbc_pkg::CMD_WR: begin
        s_nxt.burst = 1'b0;
        // void when a read was in flight and not masked the cycle before
        mem_we = !dqm && s_r.open[ba] &&
                 !(rd_busy && !s_r.dqm1);
      end
      srbc_pkg::CMD_PRE: begin
        if (addr[`SRBC_AP_BIT]) begin
          s_nxt.open = 4'h0;
        end else begin
          s_nxt.open[ba] = 1'b0;
        end
        if (stop) begin
          s_nxt.burst = 1'b0;
        end
      end
      srbc_pkg::CMD_BST: begin
        s_nxt.burst = 1'b0;
      end
      srbc_pkg::CMD_ACT: begin
        s_nxt.open[ba] = 1'b1;
        s_nxt.row[ba]  = addr;
      end
      default: begin
      end
    endcase

    // read pipeline; a write empties it so the lines go quiet
    s_nxt.pv = {s_r.pv[1:0], rd_issue};
    if (cmd == srbc_pkg::CMD_WR) begin
      s_nxt.pv = 3'h0;
    end
    s_nxt.d2   = mem_rdata;
    s_nxt.d3   = s_r.d2;
    s_nxt.dqm1 = dqm;
    s_nxt.dqm2 = s_r.dqm1;

    // write channel: address and data taken together
    aw_go   = awvalid && wvalid && !s_r.bvalid;
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (aw_go) begin
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = `SRBC_RESP_OKAY;
      if (awaddr == `SRBC_CFG_OFS) begin
        if (wstrb[0]) begin
          s_nxt.lat = (wdata[`SRBC_CFG_LAT_MSB:`SRBC_CFG_LAT_LSB] == 2'h0)
                      ? `SRBC_LAT_MIN
                      : wdata[`SRBC_CFG_LAT_MSB:`SRBC_CFG_LAT_LSB];
          s_nxt.bl  = wdata[`SRBC_CFG_BL_MSB:`SRBC_CFG_BL_LSB];
        end
      end else if (awaddr != `SRBC_STAT_OFS) begin
        s_nxt.bresp = `SRBC_RESP_SLVERR;
      end
    end

    // read channel
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (arvalid && !s_r.rvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = `SRBC_RESP_OKAY;
      s_nxt.rdata  = 32'h0000_0000;
      if (araddr == `SRBC_CFG_OFS) begin
        s_nxt.rdata[`SRBC_CFG_LAT_MSB:`SRBC_CFG_LAT_LSB] = s_r.lat;
        s_nxt.rdata[`SRBC_CFG_BL_MSB:`SRBC_CFG_BL_LSB]   = s_r.bl;
      end else if (araddr == `SRBC_STAT_OFS) begin
        s_nxt.rdata[3:0]              = s_r.open;
        s_nxt.rdata[`SRBC_STAT_BUSY]  = rd_busy;
        s_nxt.rdata[`SRBC_STAT_DRIVE] = dq_oe;
      end else begin
        s_nxt.rresp = `SRBC_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  always_comb begin
    unique case (s_r.lat)
      2'h2: begin
        dq_out = s_r.d2;
        out_v  = s_r.pv[1];
      end
      2'h3: begin
        dq_out = s_r.d3;
        out_v  = s_r.pv[2];
      end
      default: begin
        dq_out = mem_rdata;
        out_v  = s_r.pv[0];
      end
    endcase
    dq_oe = out_v && !s_r.dqm2;
  end

  assign awready = aw_go;
  assign wready  = aw_go;
  assign bvalid  = s_r.bvalid;
  assign bresp   = s_r.bresp;
  assign arready = !s_r.rvalid;
  assign rvalid  = s_r.rvalid;
  assign rresp   = s_r.rresp;
  assign rdata   = s_r.rdata;

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic rd_now, wr_now;
  assign rd_now = (cmd == srbc_pkg::CMD_RD);
  assign wr_now = (cmd == srbc_pkg::CMD_WR);

  read_lat_a: assert property (
    rd_now && s_r.lat == 2'h2 && !dqm ##1 !wr_now |-> ##1 dq_oe)
    else $error("read word missing at latency two");
  ap_flag_a: assert property (
    rd_now && m != 4'h0 |=> s_r.ap == $past(addr[`SRBC_AP_BIT]))
    else $error("auto precharge flag not kept");
  auto_close_a: assert property (
    s_r.burst && s_r.ap && !full && s_r.cnt == m && !stop
    |=> !s_r.open[$past(s_r.bank)])
    else $error("row not closed after auto precharge burst");
  end_hiz_a: assert property (
    (!s_r.burst && !rd_now)[*4] |-> !dq_oe)
    else $error("data lines driven after burst end");
  page_wrap_a: assert property (
    s_r.burst && full && !stop && s_r.cnt == 4'hF |=> s_r.cnt == 4'h0
    ##0 s_r.burst)
    else $error("full page burst did not wrap");
  gapless_a: assert property (
    rd_now && s_r.burst |=> s_r.pv[0] ##1 s_r.pv[1])
    else $error("gap at read truncation");
  wr_quiet_a: assert property (
    wr_now |=> !dq_oe)
    else $error("outputs driven after write");
  mask_lat_a: assert property (
    dqm |-> ##2 !dq_oe)
    else $error("output mask latency not two");
  in_mask_a: assert property (
    wr_now && dqm |-> !mem_we)
    else $error("masked write word stored");
  pre_stop_a: assert property (
    cmd == srbc_pkg::CMD_PRE && ba == s_r.bank |=> !s_r.burst)
    else $error("precharge did not end burst");
  bst_open_a: assert property (
    cmd == srbc_pkg::CMD_BST |=> !s_r.burst ##0
    s_r.open == $past(s_r.open))
    else $error("burst terminate changed row state");
  act_track_a: assert property (
    cmd == srbc_pkg::CMD_ACT |=> s_r.open[$past(ba)] &&
    s_r.row[$past(ba)] == $past(addr))
    else $error("activate not tracked");

  page_wrap_c: cover property (s_r.burst && full && s_r.cnt == 4'hF);
  rd_rd_c:     cover property (rd_now && s_r.burst);
  rd_wr_c:     cover property (rd_busy && wr_now && s_r.dqm1);
  bst_c:       cover property (cmd == srbc_pkg::CMD_BST && s_r.burst);

endmodule

// *** tb/srbc_ctl_model.sv ***
// Purpose : memory controller side of the command and data pins
// Assumes : commands are booked per clock edge by the bench before use
// Notes   : logs the data lines at every edge for later comparison
`timescale 1ns/1ps

module srbc_ctl_model (
  input  wire logic        aclk,    // system clock
  input  wire logic [31:0] dq_out,  // data from the device
  input  wire logic        dq_oe,   // device drives data lines
  output logic             cs_n,    // chip select, active low
  output logic             ras_n,   // row strobe, active low
  output logic             cas_n,   // column strobe, active low
  output logic             we_n,    // write enable, active low
  output logic      [1:0]  ba,      // bank address
  output logic      [11:0] addr,    // row or column address
  output logic             dqm,     // data mask
  output logic      [31:0] dq_in    // data towards the device
);
  // booked entry: valid, pins, bank, address, mask, data
  logic [50:0] sched  [0:4095];
  logic [31:0] d_log  [0:4095];
  logic        oe_log [0:4095];
  logic [50:0] nx;
  int          cyc;

  // pins are unknown until the first edge, while the block is in reset
  initial begin
    for (int i = 0; i < 4096; i++) sched[i] = '0;
  end

  task automatic put(input int e, input logic [2:0] c, input logic [1:0] b,
                     input logic [11:0] a, input logic m,
                     input logic [31:0] d);
    sched[e] = {1'b1, c, b, a, m, d};
  endtask

  // the write data driver is its own line, so no turnaround clash
  always @(posedge aclk) begin
    nx = sched[cyc+1];
    oe_log[cyc] <= dq_oe;
    d_log[cyc]  <= dq_out;
    cs_n <= ~nx[50];
    {ras_n, cas_n, we_n} <= nx[50] ? nx[49:47] : 3'h7;
    ba   <= nx[46:45];
    addr <= nx[44:33];
    dqm  <= nx[32];
    // idle data lines change every cycle
    dq_in <= (nx[50] && nx[49:47] == 3'h4) ? nx[31:0]
             : {2{cyc[15:0]}} ^ 32'h5AC3A53C;
    cyc <= cyc + 1;
  end
endmodule

// *** tb/testbench.sv ***
// Purpose : self checking bench of the read burst control block
// Assumes : register bus AXI4-Lite, command pins from srbc_ctl_model
// Notes   : expected words follow the write pattern of function wd
`timescale 1ns/1ps

module testbench;
  localparam logic [2:0] C_ACT = 3'h3, C_RD = 3'h5, C_WR = 3'h4;
  localparam logic [2:0] C_PRE = 3'h2, C_BST = 3'h6, C_NOP = 3'h7;
  localparam int ACT_GAP = 5;  // 20 ns at 4 ns, rounded up
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, dq_out, dq_in;
  logic [1:0]  bresp, rresp, ba;
  logic        cs_n, ras_n, cas_n, we_n, dqm, dq_oe;
  logic [11:0] addr;
  int          num_errors, samples_checked, e0;

  srbc_top DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe));
  srbc_ctl_model m_ctl (.aclk(aclk), .dq_out(dq_out), .dq_oe(dq_oe),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
    .addr(addr), .dqm(dqm), .dq_in(dq_in));

  always #2 aclk = ~aclk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] wd(input logic [1:0] b, input int c);
    return {20'hD0000, 2'h0, b, 4'h0, 4'(c)};
  endfunction
  function automatic logic [31:0] cfg(input int l, input logic [2:0] b);
    return {25'h0, b, 2'h0, 2'(l)};
  endfunction
  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic bad(input string what, input logic [31:0] x, y);
    num_errors++;
    $display("FAIL %s expected %h seen %h", what, x, y);
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    int i;
    i = 0;
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {a, d, 4'hF};
    {awvalid, wvalid, bready} <= 3'h7;
    do begin @(posedge aclk); i++; end
    while (!(awready === 1'b1 && wready === 1'b1) && i < 50);
    {awvalid, wvalid} <= 2'h0;
    do begin @(posedge aclk); i++; end while (bvalid !== 1'b1 && i < 99);
    bready <= 1'b0;
    samples_checked++;
    if (bvalid !== 1'b1) bad("bvalid", 1, bvalid);
    else if (bresp !== er) bad("bresp", er, bresp);
  endtask
  task automatic ck_reg(input logic [3:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    int i;
    i = 0;
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    do begin @(posedge aclk); i++; end while (arready !== 1'b1 && i < 50);
    arvalid <= 1'b0;
    do begin @(posedge aclk); i++; end while (rvalid !== 1'b1 && i < 99);
    rready <= 1'b0;
    samples_checked++;
    if (rvalid !== 1'b1) bad("rvalid", 1, rvalid);
    else if (rresp !== er) bad("rresp", er, rresp);
    else if (er === 2'h0 && rdata !== ed) bad("rdata", ed, rdata);
  endtask
  task automatic ck_w(input int e, input logic [31:0] x);
    while (m_ctl.cyc <= e) @(posedge aclk);
    samples_checked++;
    if (m_ctl.oe_log[e] !== 1'b1) bad("dq_oe high", 1, m_ctl.oe_log[e]);
    else if (m_ctl.d_log[e] !== x) bad("dq_out", x, m_ctl.d_log[e]);
  endtask
  task automatic ck_z(input int e);
    while (m_ctl.cyc <= e) @(posedge aclk);
    samples_checked++;
    if (m_ctl.oe_log[e] !== 1'b0) bad("dq_oe low", 0, m_ctl.oe_log[e]);
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
    {awaddr, araddr, wstrb, wdata} = '0;
    {num_errors, samples_checked} = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    ck_reg(4'h0, 32'h00000022, 2'h0);
    ck_reg(4'h4, 32'h00000000, 2'h0);
    ck_reg(4'h8, 32'h00000000, 2'h2);
    axi_wr(4'h8, 32'h00000003, 2'h2);
    axi_wr(4'h4, 32'h0000000F, 2'h0);
    ck_reg(4'h4, 32'h00000000, 2'h0);
    for (int l = 0; l < 4; l++) begin
      axi_wr(4'h0, cfg(l, 3'h2), 2'h0);
      ck_reg(4'h0, cfg(l == 0 ? 1 : l, 3'h2), 2'h0);
    end
    // open two rows, then fill them; the last write is masked
    e0 = m_ctl.cyc + 3;
    m_ctl.put(e0, C_ACT, 2'h0, 12'h001, 1'b0, 32'h0);
    m_ctl.put(e0 + 1, C_ACT, 2'h2, 12'h002, 1'b0, 32'h0);
    for (int c = 0; c < 16; c++) begin
      m_ctl.put(e0 + ACT_GAP + 1 + c, C_WR, 2'h0, 12'(c), 1'b0, wd(0, c));
      m_ctl.put(e0 + ACT_GAP + 17 + c, C_WR, 2'h2, 12'(c), 1'b0, wd(2, c));
    end
    m_ctl.put(e0 + 40, C_WR, 2'h0, 12'h005, 1'b1, 32'hBAD00005);
    ck_z(e0 + 42);
    ck_reg(4'h4, 32'h00000005, 2'h0);
    // read cut by a read to another bank, every latency
    for (int l = 1; l < 4; l++) begin
      axi_wr(4'h0, cfg(l, 3'h2), 2'h0);
      e0 = m_ctl.cyc + 3;
      m_ctl.put(e0, C_RD, 2'h0, 12'h003, 1'b0, 32'h0);
      m_ctl.put(e0 + 2, C_RD, 2'h2, 12'h008, 1'b0, 32'h0);
      ck_z(e0 + l - 1);
      ck_w(e0 + l, wd(0, 3));
      ck_w(e0 + l + 1, wd(0, 0));
      for (int k = 0; k < 4; k++) ck_w(e0 + l + 2 + k, wd(2, 8 + k));
      ck_z(e0 + l + 6);
    end
    // full page burst wraps, then burst terminate
    axi_wr(4'h0, cfg(3, 3'h7), 2'h0);
    e0 = m_ctl.cyc + 3;
    m_ctl.put(e0, C_RD, 2'h0, 12'h00E, 1'b0, 32'h0);
    m_ctl.put(e0 + 18, C_BST, 2'h0, 12'h000, 1'b0, 32'h0);
    ck_z(e0 + 2);
    ck_reg(4'h4, 32'h00000035, 2'h0);
    for (int k = 0; k < 18; k++) ck_w(e0 + 3 + k, wd(0, (14 + k) % 16));
    ck_z(e0 + 21);
    ck_reg(4'h4, 32'h00000005, 2'h0);
    // read to write with mask, unmasked write, then precharge
    axi_wr(4'h0, cfg(2, 3'h3), 2'h0);
    e0 = m_ctl.cyc + 3;
    m_ctl.put(e0, C_RD, 2'h0, 12'h000, 1'b0, 32'h0);
    m_ctl.put(e0 + 2, C_NOP, 2'h0, 12'h000, 1'b1, 32'h0);
    m_ctl.put(e0 + 3, C_NOP, 2'h0, 12'h000, 1'b1, 32'h0);
    m_ctl.put(e0 + 4, C_WR, 2'h2, 12'h003, 1'b0, 32'h0000A003);
    m_ctl.put(e0 + 12, C_RD, 2'h0, 12'h000, 1'b0, 32'h0);
    m_ctl.put(e0 + 14, C_WR, 2'h2, 12'h001, 1'b0, 32'hBAD00001);
    m_ctl.put(e0 + 20, C_RD, 2'h2, 12'h000, 1'b0, 32'h0);
    // bank 2 stays untouched after this, longer than the precharge period
    m_ctl.put(e0 + 24, C_PRE, 2'h2, 12'h000, 1'b0, 32'h0);
    ck_w(e0 + 2, wd(0, 0));
    ck_w(e0 + 3, wd(0, 1));
    for (int k = 4; k < 10; k++) ck_z(e0 + k);
    ck_w(e0 + 14, wd(0, 0));
    ck_z(e0 + 15);
    ck_w(e0 + 22, wd(2, 0));
    ck_w(e0 + 23, wd(2, 1));
    ck_w(e0 + 24, wd(2, 2));
    ck_w(e0 + 25, 32'h0000A003);
    ck_z(e0 + 26);
    ck_reg(4'h4, 32'h00000001, 2'h0);
    // auto precharge closes the row after the burst
    axi_wr(4'h0, cfg(2, 3'h2), 2'h0);
    e0 = m_ctl.cyc + 3;
    m_ctl.put(e0, C_RD, 2'h0, 12'h404, 1'b0, 32'h0);
    for (int k = 0; k < 4; k++) ck_w(e0 + 2 + k, wd(0, 4 + k));
    ck_z(e0 + 6);
    ck_reg(4'h4, 32'h00000000, 2'h0);
    // single word bursts at latency one, then precharge of all banks
    axi_wr(4'h0, cfg(1, 3'h0), 2'h0);
    e0 = m_ctl.cyc + 3;
    m_ctl.put(e0, C_ACT, 2'h2, 12'h002, 1'b0, 32'h0);
    m_ctl.put(e0 + ACT_GAP, C_RD, 2'h2, 12'h009, 1'b0, 32'h0);
    m_ctl.put(e0 + 6, C_RD, 2'h2, 12'h00A, 1'b0, 32'h0);
    m_ctl.put(e0 + 8, C_PRE, 2'h0, 12'h400, 1'b0, 32'h0);
    ck_z(e0 + 5);
    ck_w(e0 + 6, wd(2, 9));
    ck_w(e0 + 7, wd(2, 10));
    ck_z(e0 + 8);
    ck_reg(4'h4, 32'h00000000, 2'h0);
    report_and_stop();
  end
endmodule
